// *** hw/nffi_host.sv ***
// Rules from the document for the flash this block drives
// R1: CLE high, CE low: command byte taken on rising write strobe.
// R2: ALE high: each rising write strobe takes the next address byte.
// R3: 19-bit address in three bytes, low first, top five bits pad.
// R4: read and program send exactly three address bytes after command.
// R5: flash ignores surplus address bytes, keeping its captured address.
// R6: erase sends only the two row address bytes.
// R7: read 00h and ID read 90h are single bus cycles.
// R8: program is 80h, address, data, then confirm 10h.
// R9: erase is 60h, row address, then confirm D0h.
// R10: while busy only reset and status read are accepted.
// R11: only defined command codes are ever sent.
// R12: CE high during read abandons it.
// R13: CE high is ignored during internal program or erase.
// R14: CE is don't-care between data load and read-out cycles.
// R15: each falling read strobe drives a byte and advances the column.
// R16: flash releases the bus when deselected or output disabled.
// R17: write-protect low holds off program and erase.
// R18: ready/busy low during program, erase or frame read.
// R19: ready/busy is open-drain and driven regardless of CE.
// R20: wait at least 1 us after power-up before any command.
// R21: program and read move one 32-byte frame at a time.
// R22: erase acts on a whole 4K-byte block, 128 blocks.
// R23: frame read completes within 15 us with ready/busy low.
// R24: sequential output at no faster than 120 ns per byte.
// R25: flash sequences and verifies program and erase internally.
// R26: at most ten partial programs per frame before erase.
// R27: status byte reflects ready/busy and last pass/fail.
`timescale 1ns/1ns
module nffi_host #(
    parameter int FRAME_BYTES = nffi_pkg::FRAME_BYTES,
    parameter int ID_BYTES = nffi_pkg::ID_BYTES,
    parameter int PROG_TMO_CYC = nffi_pkg::PROG_TMO_CYC,
    parameter int ERASE_TMO_CYC = nffi_pkg::ERASE_TMO_CYC,
    parameter int BUSY_WIN_CYC = nffi_pkg::BUSY_WIN_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // user request
    input wire logic req_valid,
    input wire nffi_pkg::nffi_req_s req,
    output logic req_ready_q,
    // program data
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready_q,
    // read data and result
    output logic rd_valid_q,
    output logic [7:0] rd_data_q,
    output logic done_q,
    output logic timeout_q,
    output logic [7:0] status_q,
    // flash pins
    output nffi_pkg::nffi_pins_s pins_q,
    input wire logic [7:0] io_bus_in,
    input wire logic ready_busy_in
);
    typedef enum {S_PWR, S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_BUSYLO, S_BUSYHI, S_STCMD, S_RDATA,
        S_DONE} nffi_state_e;

    nffi_state_e state_q;
    nffi_pkg::nffi_op_e op_q;
    logic [nffi_pkg::ADDR_W-1:0] addr_q;
    logic [1:0] ai_q;
    logic [7:0] cnt_q;
    logic [nffi_pkg::TMO_W-1:0] tmo_q, tmo_lim_q;
    logic pend_q, go_q, go_rd_q, go_cle_q, go_ale_q, sel_q, wp_q, stat_rd_q;
    logic [7:0] go_byte_q;
    logic step_act_q, step_rd_q, step_done_q;
    logic [3:0] step_cnt_q;
    logic [7:0] io_s;
    logic rb_s;
    logic [1:0] ale_cnt_q;
    logic [7:0] up_cnt_q;

    if (FRAME_BYTES < 1 || FRAME_BYTES > 255 || ID_BYTES < 1 || ID_BYTES > 255 ||
        ERASE_TMO_CYC >= (1 << nffi_pkg::TMO_W) || PROG_TMO_CYC >= (1 << nffi_pkg::TMO_W) ||
        BUSY_WIN_CYC < 1 || nffi_pkg::RD_LOW_CYC + nffi_pkg::HIGH_CYC < nffi_pkg::BURST_CYC) begin : g_bad
        $error("nffi_host: parameter out of range");
    end

    // ==========================================================
    // pin synchronisers
    nffi_sync #(.W(8)) u_io_sync (.clk_sys(clk_sys), .rstn(rstn), .d(io_bus_in), .q(io_s));
    nffi_sync #(.W(1)) u_rb_sync (.clk_sys(clk_sys), .rstn(rstn), .d(ready_busy_in), .q(rb_s));

    // ==========================================================
    // bus cycle engine: one strobe per launch
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pins_q <= nffi_pkg::PINS_RESET;
            step_act_q <= 1'b0;
            step_rd_q <= 1'b0;
            step_cnt_q <= 4'h0;
            step_done_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            step_done_q <= 1'b0;
            // chip select held low for the whole operation, so read never aborts [R12] [R13] [R14]
            pins_q.ce_n <= !sel_q;
            pins_q.wp_n <= wp_q; // [R17]
            if (go_q) begin
                step_act_q <= 1'b1;
                step_rd_q <= go_rd_q;
                step_cnt_q <= 4'h0;
                pins_q.cle <= go_cle_q; // [R1]
                pins_q.ale <= go_ale_q; // [R2]
                pins_q.io_bus_out <= go_byte_q;
                // bus left to the flash during reads [R16]
                pins_q.io_bus_oe_n <= go_rd_q;
            end else if (step_act_q) begin
                step_cnt_q <= step_cnt_q + 4'h1;
                if (!step_rd_q) begin
                    if (step_cnt_q == 4'h0) pins_q.we_n <= 1'b0;
                    if (step_cnt_q == 4'(nffi_pkg::WE_LOW_CYC)) pins_q.we_n <= 1'b1;
                end else begin
                    if (step_cnt_q == 4'h0) pins_q.read_strobe_n <= 1'b0; // [R15]
                    if (step_cnt_q == 4'(nffi_pkg::RD_LOW_CYC)) begin
                        // synced bus lags two cycles; low phase is long enough to see settled data
                        pins_q.read_strobe_n <= 1'b1;
                        rd_data_q <= io_s; // [R15]
                    end
                end
                if (step_cnt_q == 4'((step_rd_q ? nffi_pkg::RD_LOW_CYC : nffi_pkg::WE_LOW_CYC) +
                    nffi_pkg::HIGH_CYC)) begin
                    step_act_q <= 1'b0;
                    step_done_q <= 1'b1;
                    pins_q.cle <= 1'b0;
                    pins_q.ale <= 1'b0;
                    pins_q.io_bus_oe_n <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // operation sequencer
    function automatic logic [7:0] addr_byte(input logic [nffi_pkg::ADDR_W-1:0] a, input logic [1:0] i);
        case (i)
            nffi_pkg::ADDR_FIRST: addr_byte = a[7:0];
            nffi_pkg::ADDR_ROW_FIRST: addr_byte = a[15:8];
            default: addr_byte = {nffi_pkg::ADDR_PAD, a[18:16]}; // [R3]
        endcase
    endfunction

    function automatic logic [7:0] first_code(input nffi_pkg::nffi_op_e op);
        // only codes of the defined set leave this block [R11]
        case (op)
            nffi_pkg::OP_READ: first_code = nffi_pkg::CMD_READ; // [R7]
            nffi_pkg::OP_PROG: first_code = nffi_pkg::CMD_PROG_SETUP; // [R8]
            nffi_pkg::OP_ERASE: first_code = nffi_pkg::CMD_ERASE_SETUP; // [R9]
            nffi_pkg::OP_STATUS: first_code = nffi_pkg::CMD_STATUS;
            nffi_pkg::OP_ID: first_code = nffi_pkg::CMD_ID; // [R7]
            default: first_code = nffi_pkg::CMD_RESET;
        endcase
    endfunction

    task automatic issue(input logic rd, input logic cle, input logic ale, input logic [7:0] b);
        go_q <= 1'b1;
        go_rd_q <= rd;
        go_cle_q <= cle;
        go_ale_q <= ale;
        go_byte_q <= b;
        pend_q <= 1'b1;
    endtask

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_PWR;
            op_q <= nffi_pkg::OP_READ;
            addr_q <= '0;
            ai_q <= 2'h0;
            cnt_q <= 8'h00;
            tmo_q <= '0;
            tmo_lim_q <= '0;
            pend_q <= 1'b0;
            go_q <= 1'b0;
            go_rd_q <= 1'b0;
            go_cle_q <= 1'b0;
            go_ale_q <= 1'b0;
            go_byte_q <= 8'h00;
            sel_q <= 1'b0;
            wp_q <= 1'b0;
            stat_rd_q <= 1'b0;
            req_ready_q <= 1'b0;
            wr_ready_q <= 1'b0;
            rd_valid_q <= 1'b0;
            done_q <= 1'b0;
            timeout_q <= 1'b0;
            status_q <= 8'h00;
        end else begin
            go_q <= 1'b0;
            rd_valid_q <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
                S_PWR: begin
                    // power-up recovery before the first command [R20]
                    if (tmo_q == nffi_pkg::TMO_W'(nffi_pkg::PWRUP_CYC - 1)) begin
                        state_q <= S_IDLE;
                        tmo_q <= '0;
                    end else tmo_q <= tmo_q + 1'b1;
                end
                S_IDLE: begin
                    if (req_valid && req_ready_q) begin
                        // caller keeps partial programs of one frame within the limit [R26]
                        req_ready_q <= 1'b0;
                        op_q <= req.op;
                        addr_q <= req.addr;
                        sel_q <= 1'b1;
                        wp_q <= (req.op == nffi_pkg::OP_PROG) || (req.op == nffi_pkg::OP_ERASE); // [R17]
                        timeout_q <= 1'b0;
                        cnt_q <= 8'h00;
                        ai_q <= (req.op == nffi_pkg::OP_ERASE) ? nffi_pkg::ADDR_ROW_FIRST :
                            nffi_pkg::ADDR_FIRST; // [R6]
                        case (req.op)
                            nffi_pkg::OP_READ: tmo_lim_q <= nffi_pkg::TMO_W'(nffi_pkg::RDBUSY_CYC); // [R23]
                            nffi_pkg::OP_ERASE: tmo_lim_q <= nffi_pkg::TMO_W'(ERASE_TMO_CYC);
                            default: tmo_lim_q <= nffi_pkg::TMO_W'(PROG_TMO_CYC);
                        endcase
                        state_q <= S_CMD1;
                    end else req_ready_q <= rb_s; // nothing new while busy [R10]
                end
                S_CMD1: begin
                    if (!pend_q) issue(1'b0, 1'b1, 1'b0, first_code(op_q)); // [R1]
                    else if (step_done_q) begin
                        pend_q <= 1'b0;
                        tmo_q <= '0;
                        case (op_q)
                            nffi_pkg::OP_STATUS: begin
                                state_q <= S_RDATA;
                                cnt_q <= 8'h01;
                                stat_rd_q <= 1'b1;
                            end
                            nffi_pkg::OP_RESET: state_q <= S_BUSYLO;
                            default: state_q <= S_ADDR;
                        endcase
                    end
                end
                S_ADDR: begin
                    if (!pend_q) issue(1'b0, 1'b0, 1'b1, (op_q == nffi_pkg::OP_ID) ? nffi_pkg::ID_ADDR_BYTE :
                        addr_byte(addr_q, ai_q)); // [R2]
                    else if (step_done_q) begin
                        pend_q <= 1'b0;
                        ai_q <= ai_q + 2'h1;
                        // exactly three bytes for read and program, two for erase [R4] [R6]
                        if (ai_q == nffi_pkg::ADDR_LAST || op_q == nffi_pkg::OP_ID) begin
                            tmo_q <= '0;
                            case (op_q)
                                nffi_pkg::OP_READ: state_q <= S_BUSYLO;
                                nffi_pkg::OP_PROG: begin
                                    state_q <= S_WDATA;
                                    wr_ready_q <= 1'b1;
                                end
                                nffi_pkg::OP_ERASE: state_q <= S_CMD2;
                                default: begin
                                    state_q <= S_RDATA;
                                    cnt_q <= 8'(ID_BYTES);
                                end
                            endcase
                        end
                    end
                end
                S_WDATA: begin
                    if (wr_ready_q && wr_valid) begin
                        wr_ready_q <= 1'b0;
                        issue(1'b0, 1'b0, 1'b0, wr_data);
                    end else if (pend_q && step_done_q) begin
                        pend_q <= 1'b0;
                        // one frame per program [R21]
                        if (cnt_q == 8'(FRAME_BYTES - 1)) state_q <= S_CMD2;
                        else begin
                            cnt_q <= cnt_q + 8'h01;
                            wr_ready_q <= 1'b1;
                        end
                    end
                end
                S_CMD2: begin
                    if (!pend_q) issue(1'b0, 1'b1, 1'b0, (op_q == nffi_pkg::OP_PROG) ? nffi_pkg::CMD_PROG_GO :
                        nffi_pkg::CMD_ERASE_GO); // [R8] [R9]
                    else if (step_done_q) begin
                        pend_q <= 1'b0;
                        tmo_q <= '0;
                        state_q <= S_BUSYLO;
                    end
                end
                S_BUSYLO: begin
                    // busy may never be seen if the flash is quick; give it a short window [R18]
                    if (!rb_s || tmo_q == nffi_pkg::TMO_W'(BUSY_WIN_CYC - 1)) begin
                        state_q <= S_BUSYHI;
                        tmo_q <= '0;
                    end else tmo_q <= tmo_q + 1'b1;
                end
                S_BUSYHI: begin
                    // ready/busy is driven even while deselected, so it is trusted here [R19]
                    if (rb_s || tmo_q == tmo_lim_q) begin
                        timeout_q <= !rb_s; // [R23]
                        tmo_q <= '0;
                        case (op_q)
                            nffi_pkg::OP_READ: begin
                                state_q <= S_RDATA;
                                cnt_q <= 8'(FRAME_BYTES); // [R21]
                            end
                            nffi_pkg::OP_PROG, nffi_pkg::OP_ERASE: state_q <= S_STCMD; // [R25]
                            default: state_q <= S_DONE;
                        endcase
                    end else tmo_q <= tmo_q + 1'b1;
                end
                S_STCMD: begin
                    if (!pend_q) issue(1'b0, 1'b1, 1'b0, nffi_pkg::CMD_STATUS);
                    else if (step_done_q) begin
                        pend_q <= 1'b0;
                        state_q <= S_RDATA;
                        cnt_q <= 8'h01;
                        stat_rd_q <= 1'b1;
                    end
                end
                S_RDATA: begin
                    if (!pend_q) issue(1'b1, 1'b0, 1'b0, nffi_pkg::IDLE_BYTE); // [R15]
                    else if (step_done_q) begin
                        pend_q <= 1'b0;
                        if (stat_rd_q) status_q <= rd_data_q; // [R27]
                        else rd_valid_q <= 1'b1;
                        if (cnt_q == 8'h01) state_q <= S_DONE;
                        else cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    sel_q <= 1'b0;
                    wp_q <= 1'b0;
                    stat_rd_q <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // checks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ale_cnt_q <= 2'h0;
            up_cnt_q <= 8'h00;
        end else begin
            if (up_cnt_q != 8'hFF) up_cnt_q <= up_cnt_q + 8'h01;
            if (state_q == S_IDLE) ale_cnt_q <= 2'h0;
            else if (pins_q.we_n && step_act_q && pins_q.ale && step_cnt_q == 4'(nffi_pkg::WE_LOW_CYC + 1))
                ale_cnt_q <= ale_cnt_q + 2'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_we_pulse;
        (!pins_q.we_n) [*2] ##1 pins_q.we_n [*4];
    endsequence
    sequence s_rd_pulse;
        (!pins_q.read_strobe_n) [*3] ##1 pins_q.read_strobe_n [*4];
    endsequence

    AST_CMD_LATCH: assert property ($rose(pins_q.we_n) && pins_q.cle |-> // [R1]
        !pins_q.ce_n && !pins_q.ale && !pins_q.io_bus_oe_n) else $error("command latch malformed");
    AST_WE_PULSE: assert property ($fell(pins_q.we_n) |-> s_we_pulse) else $error("write strobe timing"); // [R1]
    AST_ADDR_LATCH: assert property ($rose(pins_q.we_n) && pins_q.ale |-> // [R2]
        !pins_q.cle && !pins_q.ce_n) else $error("address latch malformed");
    AST_ADDR_PAD: assert property ($rose(pins_q.we_n) && pins_q.ale && ai_q == 2'h2 |-> // [R3]
        pins_q.io_bus_out[7:3] == 5'h00) else $error("third address byte not padded");
    AST_ADDR_THREE: assert property (state_q == S_WDATA || // [R4]
        (state_q == S_BUSYLO && op_q == nffi_pkg::OP_READ) |->
        ale_cnt_q == 2'h3) else $error("wrong address count for read or program");
    AST_ADDR_TWO: assert property (state_q == S_CMD2 && op_q == nffi_pkg::OP_ERASE |-> // [R6]
        ale_cnt_q == 2'h2) else $error("wrong address count for erase");
    AST_PROG_GO: assert property ($rose(pins_q.we_n) && pins_q.cle && // [R8]
        pins_q.io_bus_out == nffi_pkg::CMD_PROG_GO |->
        op_q == nffi_pkg::OP_PROG && pins_q.wp_n) else $error("program confirm out of place");
    AST_ERASE_GO: assert property ($rose(pins_q.we_n) && pins_q.cle && // [R9]
        pins_q.io_bus_out == nffi_pkg::CMD_ERASE_GO |->
        op_q == nffi_pkg::OP_ERASE && pins_q.wp_n) else $error("erase confirm out of place");
    AST_BUSY_GUARD: assert property (req_valid && req_ready_q |-> rb_s) else $error("request taken while busy"); // [R10]
    AST_READ_SEL: assert property (!pins_q.read_strobe_n |-> // [R12]
        !pins_q.ce_n && pins_q.io_bus_oe_n) else $error("read strobe without select or with drive");
    AST_PWRUP: assert property (req_ready_q |-> up_cnt_q >= 8'(nffi_pkg::PWRUP_CYC)) // [R20]
        else $error("ready before power-up wait");
    AST_RD_PULSE: assert property ($fell(pins_q.read_strobe_n) |-> s_rd_pulse) else $error("read burst too fast"); // [R24]
endmodule // nffi_host

// *** hw/nffi_pkg.sv ***
package nffi_pkg;
    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] ID_ADDR_BYTE = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'h00;

    // ==========================================================
    // address layout
    localparam int ADDR_W = 19;
    localparam logic [1:0] ADDR_FIRST = 2'h0;
    localparam logic [1:0] ADDR_ROW_FIRST = 2'h1;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    localparam logic [4:0] ADDR_PAD = 5'h00;
    localparam int FRAME_BYTES = 32;
    localparam int ID_BYTES = 2;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 25;
    localparam int T_PWRUP_NS = 1000;
    localparam int T_RAND_READ_NS = 15000;
    localparam int T_PROG_MAX_NS = 1000000;
    localparam int T_ERASE_MAX_NS = 10000000;
    localparam int T_BURST_NS = 120;
    localparam int T_WE_LOW_NS = 80;
    localparam int T_STROBE_HIGH_NS = 80;
    localparam int PWRUP_CYC = (T_PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int RDBUSY_CYC = T_RAND_READ_NS * CLK_MHZ / 1000;
    localparam int PROG_TMO_CYC = T_PROG_MAX_NS * CLK_MHZ / 1000;
    localparam int ERASE_TMO_CYC = T_ERASE_MAX_NS * CLK_MHZ / 1000;
    localparam int BURST_CYC = (T_BURST_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int HIGH_CYC = (T_STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_STAGES = 2;
    localparam int RD_LOW_CYC = SYNC_STAGES + 1;
    localparam int TMO_W = 24;
    localparam int BUSY_WIN_CYC = 8;

    // ==========================================================
    // types
    typedef enum logic [2:0] {OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_ID, OP_RESET} nffi_op_e;

    typedef struct packed {
        nffi_op_e op;
        logic [ADDR_W-1:0] addr;
    } nffi_req_s;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
        logic io_bus_oe_n;
        logic [7:0] io_bus_out;
    } nffi_pins_s;

    localparam nffi_pins_s PINS_RESET = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
        read_strobe_n: 1'b1, wp_n: 1'b0, io_bus_oe_n: 1'b1, io_bus_out: 8'h00};
endpackage

// *** hw/nffi_sync.sv ***
`timescale 1ns/1ns
module nffi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_bad_w
        $error("nffi_sync: width must be at least one");
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // nffi_sync

// *** test/nand_frame_flash_interface_tb_top.sv ***
`timescale 1ns/1ns
module nand_frame_flash_interface_tb_top;
    logic clk_sys, rstn, req_valid, wr_valid, req_ready_q, wr_ready_q, rd_valid_q, done_q, timeout_q, ready_busy_in;
    logic [7:0] wr_data, rd_data_q, status_q, io_bus_in;
    nffi_pkg::nffi_req_s req;
    nffi_pkg::nffi_pins_s pins_q;
    logic [7:0] ref_mem [int];
    logic [7:0] exp_q [$];
    logic [7:0] wq [32];
    logic [18:0] a;
    int err_count, checked, wi;
    localparam logic [15:0] ID = 16'h5AC3; // arbitrary
    nffi_host #(.PROG_TMO_CYC(200), .ERASE_TMO_CYC(200)) nffi_host_inst (.clk_sys(clk_sys), .rstn(rstn),
        .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready_q(wr_ready_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .done_q(done_q),
        .timeout_q(timeout_q), .status_q(status_q), .pins_q(pins_q), .io_bus_in(io_bus_in),
        .ready_busy_in(ready_busy_in));
    nffi_flash_model #(.ID(ID)) nffi_flash_model_inst (.pins(pins_q), .io_bus_in(io_bus_in),
        .ready_busy_in(ready_busy_in));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_hi(input bit on_done);
        int k;
        for (k = 0; k < 3000 && (on_done ? done_q : req_ready_q) !== 1'b1; k++) @(posedge clk_sys);
        if (k == 3000) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic run(input nffi_pkg::nffi_op_e op);
        if (op == nffi_pkg::OP_ID) exp_q = {ID[15:8], ID[7:0]};
        if (op == nffi_pkg::OP_READ) begin
            for (int i = 0; i < 32; i++) exp_q.push_back(ref_mem.exists(a + i) ? ref_mem[a + i] : 8'hFF);
        end
        wait_hi(1'b0);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(posedge clk_sys);
        wait_hi(1'b1);
        chk({7'h00, timeout_q}, 8'h00, "timeout");
    endtask
    // ========================================
    // every read byte against the reference
    always @(posedge clk_sys) if (rd_valid_q === 1'b1) begin
        chk(rd_data_q, exp_q.size() ? exp_q.pop_front() : 8'hXX, "read byte");
    end
    always @(posedge clk_sys) if (wr_valid && wr_ready_q) begin
        wi = wi + 1;
        wr_data <= wq[wi[4:0]];
    end
    initial begin
        {rstn, req_valid, wr_valid, wr_data, req} = '0;
        {err_count, checked, wi} = '0;
        a = '0;
        void'($urandom(32'h290A));
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        run(nffi_pkg::OP_ID);
        repeat (2) begin
            a = {7'($urandom_range(127)), 7'($urandom_range(127)), 5'h00};
            run(nffi_pkg::OP_READ);
            foreach (wq[i]) wq[i] = 8'($urandom);
            wi = 0;
            wr_data <= wq[0];
            wr_valid <= 1'b1;
            run(nffi_pkg::OP_PROG);
            wr_valid <= 1'b0;
            chk(status_q, 8'hC0, "program status");
            foreach (wq[i]) ref_mem[a + i] = wq[i];
            run(nffi_pkg::OP_READ);
            run(nffi_pkg::OP_ERASE);
            chk(status_q, 8'hC0, "erase status");
            ref_mem.delete();
            run(nffi_pkg::OP_READ);
        end
        run(nffi_pkg::OP_STATUS);
        chk(status_q, 8'hC0, "status");
        run(nffi_pkg::OP_RESET);
        chk(8'(exp_q.size()), 8'h00, "pending reads");
        end_sim();
    end
endmodule // nand_frame_flash_interface_tb_top

// *** test/nffi_flash_model.sv ***
`timescale 1ns/1ns
module nffi_flash_model #(
    parameter logic [15:0] ID = 16'h0000
) (
    // flash pins
    input wire nffi_pkg::nffi_pins_s pins,
    output logic [7:0] io_bus_in,
    output logic ready_busy_in
);
    logic [7:0] mem [int];
    logic [7:0] cmd, st;
    logic [7:0] dreg [32];
    logic [18:0] adr;
    logic [4:0] col;
    int ac;
    function automatic logic [7:0] rd(input int k);
        return mem.exists(k) ? mem[k] : 8'hFF;
    endfunction
    task automatic busy(input int t);
        ready_busy_in = 1'b0;
        fork #(t) ready_busy_in = 1'b1; join_none
    endtask
    initial begin
        {io_bus_in, cmd, st, adr, col} = '0;
        ac = 0;
        ready_busy_in = 1'b1;
    end
    // ========================================
    // write strobe
    always @(posedge pins.we_n) begin
        if (pins.ce_n) begin
        end else if (pins.cle && (ready_busy_in || pins.io_bus_out inside {8'hFF, 8'h70})) begin
            cmd = pins.io_bus_out;
            ac = (cmd == 8'h60);
            if (cmd == 8'h80) foreach (dreg[i]) dreg[i] = 8'hFF;
            if (cmd == 8'hFF) busy(400);
            if (cmd == 8'h10 || cmd == 8'hD0) begin
                st = pins.wp_n ? 8'hC0 : 8'h01;
                if (pins.wp_n && cmd == 8'h10) foreach (dreg[i]) begin
                    mem[{adr[18:5], i[4:0]}] = dreg[i] & rd({adr[18:5], i[4:0]});
                end
                if (pins.wp_n && cmd == 8'hD0) for (int i = 0; i < 4096; i++) begin
                    mem.delete({adr[18:12], i[11:0]});
                end
                busy(4000);
            end
        end else if (pins.ale && ac < ((cmd == 8'h90) ? 1 : 3)) begin
            case (ac)
                0: adr[7:0] = pins.io_bus_out;
                1: adr[15:8] = pins.io_bus_out;
                default: adr[18:16] = pins.io_bus_out[2:0];
            endcase
            ac++;
            col = (cmd == 8'h90) ? 5'h00 : adr[4:0];
            if (ac == 3 && cmd == 8'h00) begin
                foreach (dreg[i]) dreg[i] = rd({adr[18:5], i[4:0]});
                busy(4000);
            end
        end else if (cmd == 8'h80) begin
            dreg[col] = pins.io_bus_out;
            col++;
        end
    end
    // ========================================
    // read strobe
    always @(negedge pins.read_strobe_n) begin
        #30;
        io_bus_in = (cmd == 8'h70) ? st : (cmd == 8'h90) ? (col[0] ? ID[7:0] : ID[15:8]) : dreg[col];
        col++;
    end
    // released bus shows the inverse so a stale byte never passes as valid
    always @(posedge pins.read_strobe_n or posedge pins.ce_n) io_bus_in = ~io_bus_in;
    always @(posedge pins.ce_n) if (ready_busy_in) cmd = 8'h01;
endmodule // nffi_flash_model
